// file: include/scl_params.svh
// Constants for the strap configuration latch
//
// Operation
// - Every configuration strap is sampled at hardware reset and held as the default.
// - Configuration input zero loads the two low bits of the station address.
// - Configuration input one loads the pause advertisement bit and address bit two.
// - Configuration input two loads the two low bits of the extended mode field.
// - Configuration input three, LINK1000_INDICATOR or supply only, loads mode bit three.
// - Separate link indicators are driven for 10, 100 and 1000 Mbit/s.
// - A dedicated activity indicator shows traffic over the established link.
// - Management uses an input-only clock and one shared bidirectional data line.
// - The device is in hardware power-down whenever the power-down input is asserted.
// - The active-low reset pin is a hardware reset that resamples straps and reinitialises.
`ifndef SCL_PARAMS_SVH
`define SCL_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define SCL_CLK_PERIOD_NS 25
`define SCL_SETTLE_NS     1000
`define SCL_SETTLE_CYC    ((`SCL_SETTLE_NS + `SCL_CLK_PERIOD_NS - 1) / `SCL_CLK_PERIOD_NS)
`define SCL_ACT_HOLD_NS   40000
`define SCL_ACT_HOLD_CYC  (`SCL_ACT_HOLD_NS / `SCL_CLK_PERIOD_NS)
`define SCL_CNT_W         16

// ----------------------------------------
// Register map
// ----------------------------------------
`define SCL_ADDR_W       12
`define SCL_ADDR_STATUS  12'h000
`define SCL_ADDR_MODES   12'h004
`define SCL_ADDR_CTRL    12'h008
`define SCL_ADDR_MGMT    12'h00c

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SCL_F_ADDR_LO    0
`define SCL_F_ADDR_HI    2
`define SCL_F_PAUSE      3
`define SCL_F_MODE_LO    4
`define SCL_F_MODE_HI    7
`define SCL_F_POLICY     8
`define SCL_F_DONE       9
`define SCL_F_PD         10
`define SCL_F_PLL        11
`define SCL_F_LED_EN     0
`define SCL_F_MDC        0
`define SCL_F_MDIO_IN    1
`define SCL_F_MDIO_OUT   2
`define SCL_F_MDIO_OE    3
`define SCL_MODES_RST    8'h00
`define SCL_CTRL_RST     1'b1
`define SCL_SYNC_W       9
`define SCL_SPEED_10     2'b00
`define SCL_SPEED_100    2'b01
`define SCL_SPEED_1000   2'b10

`endif

// file: include/scl_pkg.sv
// Types for the strap configuration latch
package scl_pkg;

  typedef enum logic [1:0]
  {
    SCL_ST_IDLE    = 2'b00,
    SCL_ST_DRIVE_A = 2'b01,
    SCL_ST_DRIVE_B = 2'b10,
    SCL_ST_DONE    = 2'b11
  } scl_state_e;

endpackage

// file: rtl/scl_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module scl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// file: rtl/scl_top.sv
// Strap configuration latch with indicators, power-down policy and APB registers
`timescale 1ns/1ps
`include "scl_params.svh"
module scl_top
  import scl_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   sys_reset_n,
  input  wire logic                   cfg_strap_zero,
  input  wire logic                   cfg_strap_one,
  input  wire logic                   cfg_strap_two,
  input  wire logic                   cfg_strap_three,
  input  wire logic                   powerdown_pll_policy_strap,
  input  wire logic                   hw_powerdown_in,
  input  wire logic                   link_up,
  input  wire logic [1:0]             link_speed,
  input  wire logic                   activity_event,
  input  wire logic                   mdc,
  input  wire logic                   mdio_in,
  output logic                        mdio_out,
  output logic                        mdio_oe,
  output logic                        link10_indicator,
  output logic                        link100_indicator,
  output logic                        link1000_indicator,
  output logic                        activity_indicator,
  output logic                        powerdown_active,
  output logic                        pll_enable,
  output logic [2:0]                  phy_station_addr,
  output logic                        pause_adv,
  output logic [3:0]                  ext_mode_field,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`SCL_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  logic [`SCL_SYNC_W-1:0] pins_s;
  logic s_c0, s_c1, s_c2, s_c3, s_pol, s_rstn, s_pd, s_mdc, s_mdio;

  scl_sync #(.WIDTH(`SCL_SYNC_W)) u_sync (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .async_in ({mdio_in, mdc, hw_powerdown_in, sys_reset_n, powerdown_pll_policy_strap,
                cfg_strap_three, cfg_strap_two, cfg_strap_one, cfg_strap_zero}),
    .sync_out (pins_s)
  );

  assign {s_mdio, s_mdc, s_pd, s_rstn, s_pol, s_c3, s_c2, s_c1, s_c0} = pins_s;

  // Synchroniser resets low, so a fresh start always runs a strap pass
  logic hw_rst;
  assign hw_rst = ~s_rstn;

  // ----------------------------------------
  // Strap decode
  // ----------------------------------------
  // Phase A drives LINK1000_INDICATOR high, phase B drives LINK100_INDICATOR high
  function automatic logic [1:0] strap_code(input logic in_a, input logic in_b);
    strap_code = {in_a, in_b};
  endfunction

  // ----------------------------------------
  // Strap sampling sequence
  // ----------------------------------------
  scl_state_e           st_q, st_d;
  logic [`SCL_CNT_W-1:0] cnt_q, cnt_d;
  logic [2:0]           sa_q, sa_d;
  logic [2:0]           l_addr_q, l_addr_d;
  logic                 l_pause_q, l_pause_d;
  logic [3:0]           l_mode_q, l_mode_d;
  logic                 l_pol_q, l_pol_d;
  logic                 settled;
  logic [1:0]           c0, c1, c2;

  assign settled = (cnt_q == `SCL_CNT_W'(`SCL_SETTLE_CYC - 1));
  assign c0 = strap_code(sa_q[0], s_c0);
  assign c1 = strap_code(sa_q[1], s_c1);
  assign c2 = strap_code(sa_q[2], s_c2);

  always_comb
  begin
    st_d      = st_q;
    cnt_d     = settled ? '0 : cnt_q + `SCL_CNT_W'(1);
    sa_d      = sa_q;
    l_addr_d  = l_addr_q;
    l_pause_d = l_pause_q;
    l_mode_d  = l_mode_q;
    l_pol_d   = l_pol_q;
    case (st_q)
      SCL_ST_IDLE:
      begin
        // Indicators quiet, so the shared 100 pin shows its resistor
        if (settled)
        begin
          l_pol_d = s_pol;
          st_d    = SCL_ST_DRIVE_A;
        end
      end
      SCL_ST_DRIVE_A:
      begin
        if (settled)
        begin
          sa_d = {s_c2, s_c1, s_c0};
          st_d = SCL_ST_DRIVE_B;
        end
      end
      SCL_ST_DRIVE_B:
      begin
        if (settled)
        begin
          l_addr_d  = {c1[1], c0};
          l_pause_d = c1[0];
          l_mode_d  = {s_c3, 1'b0, c2};
          st_d      = SCL_ST_DONE;
        end
      end
      SCL_ST_DONE:
      begin
        cnt_d = '0;
      end
      default:
      begin
        st_d = SCL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q      <= SCL_ST_IDLE;
      cnt_q     <= '0;
      sa_q      <= '0;
      l_addr_q  <= '0;
      l_pause_q <= 1'b0;
      l_mode_q  <= '0;
      l_pol_q   <= 1'b0;
    end
    else if (hw_rst)
    begin
      st_q      <= SCL_ST_IDLE;
      cnt_q     <= '0;
      sa_q      <= '0;
      l_addr_q  <= '0;
      l_pause_q <= 1'b0;
      l_mode_q  <= '0;
      l_pol_q   <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      sa_q      <= sa_d;
      l_addr_q  <= l_addr_d;
      l_pause_q <= l_pause_d;
      l_mode_q  <= l_mode_d;
      l_pol_q   <= l_pol_d;
    end
  end

  // ----------------------------------------
  // Registers, indicators and power-down
  // ----------------------------------------
  logic [7:0]            modes_q, modes_d;
  logic                  led_en_q, led_en_d;
  logic                  mo_q, mo_d, moe_q, moe_d;
  logic [31:0]           rd_q, rd_d;
  logic                  rdy_q, rdy_d, err_q, err_d;
  logic                  l10_q, l10_d, l100_q, l100_d, l1000_q, l1000_d;
  logic [`SCL_CNT_W-1:0] act_cnt_q, act_cnt_d;
  logic                  act_q, act_d, pd_q, pd_d, pll_q, pll_d;
  logic                  done, setup, wr;
  logic [31:0]           status_v;

  assign done  = (st_q == SCL_ST_DONE);
  assign setup = psel & ~penable;
  assign wr    = psel & penable & rdy_q & pwrite & ~err_q;

  always_comb
  begin
    status_v = '0;
    status_v[`SCL_F_ADDR_HI:`SCL_F_ADDR_LO] = l_addr_q;
    status_v[`SCL_F_PAUSE]                  = l_pause_q;
    status_v[`SCL_F_MODE_HI:`SCL_F_MODE_LO] = l_mode_q;
    status_v[`SCL_F_POLICY]                 = l_pol_q;
    status_v[`SCL_F_DONE]                   = done;
    status_v[`SCL_F_PD]                     = pd_q;
    status_v[`SCL_F_PLL]                    = pll_q;
  end

  always_comb
  begin
    modes_d  = modes_q;
    led_en_d = led_en_q;
    mo_d     = mo_q;
    moe_d    = moe_q;
    rd_d     = rd_q;
    rdy_d    = 1'b0;
    err_d    = 1'b0;
    // Working copy takes the latched defaults once, as the pass ends
    if (st_q == SCL_ST_DRIVE_B && st_d == SCL_ST_DONE)
    begin
      modes_d = {l_mode_d, l_pause_d, l_addr_d};
    end
    // No wait state: answer is prepared in the setup cycle
    if (setup)
    begin
      rdy_d = 1'b1;
      rd_d  = '0;
      case (paddr)
        `SCL_ADDR_STATUS: rd_d = status_v;
        `SCL_ADDR_MODES:  rd_d[`SCL_F_MODE_HI:`SCL_F_ADDR_LO] = modes_q;
        `SCL_ADDR_CTRL:   rd_d[`SCL_F_LED_EN] = led_en_q;
        `SCL_ADDR_MGMT:   rd_d[`SCL_F_MDIO_OE:`SCL_F_MDC] = {moe_q, mo_q, s_mdio, s_mdc};
        default:          err_d = 1'b1;
      endcase
    end
    else if (psel & penable & ~rdy_q)
    begin
      rdy_d = 1'b1;
      err_d = err_q;
    end
    if (wr)
    begin
      case (paddr)
        `SCL_ADDR_MODES: modes_d  = pwdata[`SCL_F_MODE_HI:`SCL_F_ADDR_LO];
        `SCL_ADDR_CTRL:  led_en_d = pwdata[`SCL_F_LED_EN];
        `SCL_ADDR_MGMT:
        begin
          mo_d  = pwdata[`SCL_F_MDIO_OUT];
          moe_d = pwdata[`SCL_F_MDIO_OE];
        end
        default: ;
      endcase
    end
    // The 100 and 1000 indicators double as strap stimulus until the pass is done
    l10_d   = led_en_q & done & link_up & (link_speed == `SCL_SPEED_10);
    l100_d  = (st_q == SCL_ST_DRIVE_B) |
              (led_en_q & done & link_up & (link_speed == `SCL_SPEED_100));
    l1000_d = (st_q == SCL_ST_DRIVE_A) |
              (led_en_q & done & link_up & (link_speed == `SCL_SPEED_1000));
    // Stretch each event, so short bursts stay visible
    act_cnt_d = act_cnt_q;
    if (link_up & activity_event)
    begin
      act_cnt_d = `SCL_CNT_W'(`SCL_ACT_HOLD_CYC);
    end
    else if (act_cnt_q != '0)
    begin
      act_cnt_d = act_cnt_q - `SCL_CNT_W'(1);
    end
    act_d = led_en_q & done & link_up & (act_cnt_d != '0);
    pd_d  = s_pd;
    pll_d = ~(s_pd & ~l_pol_q);
  end

  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      modes_q   <= `SCL_MODES_RST;
      led_en_q  <= `SCL_CTRL_RST;
      mo_q      <= 1'b0;
      moe_q     <= 1'b0;
      rd_q      <= '0;
      rdy_q     <= 1'b0;
      err_q     <= 1'b0;
      l10_q     <= 1'b0;
      l100_q    <= 1'b0;
      l1000_q   <= 1'b0;
      act_cnt_q <= '0;
      act_q     <= 1'b0;
      pd_q      <= 1'b0;
      pll_q     <= 1'b1;
    end
    else
    begin
      modes_q   <= hw_rst ? `SCL_MODES_RST : modes_d;
      led_en_q  <= hw_rst ? `SCL_CTRL_RST : led_en_d;
      mo_q      <= hw_rst ? 1'b0 : mo_d;
      moe_q     <= hw_rst ? 1'b0 : moe_d;
      rd_q      <= rd_d;
      rdy_q     <= rdy_d;
      err_q     <= err_d;
      l10_q     <= l10_d;
      l100_q    <= l100_d;
      l1000_q   <= l1000_d;
      act_cnt_q <= hw_rst ? '0 : act_cnt_d;
      act_q     <= act_d;
      pd_q      <= pd_d;
      pll_q     <= pll_d;
    end
  end

  assign mdio_out           = mo_q;
  assign mdio_oe            = moe_q;
  assign link10_indicator   = l10_q;
  assign link100_indicator  = l100_q;
  assign link1000_indicator = l1000_q;
  assign activity_indicator = act_q;
  assign powerdown_active   = pd_q;
  assign pll_enable         = pll_q;
  assign phy_station_addr   = modes_q[`SCL_F_ADDR_HI:`SCL_F_ADDR_LO];
  assign pause_adv          = modes_q[`SCL_F_PAUSE];
  assign ext_mode_field     = modes_q[`SCL_F_MODE_HI:`SCL_F_MODE_LO];
  assign prdata             = rd_q;
  assign pready             = rdy_q;
  assign pslverr            = err_q;

endmodule

// file: tb/scl_board.sv
// Board model: strap resistors, policy pull and data-line pull-up
`timescale 1ns/1ps
module scl_board (
  input  wire logic [7:0] sel,
  input  wire logic       pol_up,
  input  wire logic       l100,
  input  wire logic       l1000,
  input  wire logic       oe,
  input  wire logic       dout,
  output logic      [3:0] strap,
  output logic            pol,
  output logic            din
);
  // ----------------------------------------
  // Wiring
  // ----------------------------------------
  // Strap k tied to ground, 100 pin, 1000 pin or supply, chosen by sel[2k+1:2k]
  always_comb
  begin
    for (int k = 0; k < 4; k++)
      strap[k] = sel[2*k+1] ? (sel[2*k] | l1000) : (sel[2*k] & l100);
    pol = l100 | pol_up;
    din = oe ? dout : 1'b1;
  end
endmodule

// file: tb/scl_chk.sv
// Port-level assertions for the strap latch
`timescale 1ns/1ps
`include "scl_params.svh"
module scl_chk (
  input wire logic                   sys_clk,
  input wire logic                   sys_rst,
  input wire logic                   sys_reset_n,
  input wire logic                   hw_powerdown_in,
  input wire logic                   link_up,
  input wire logic [1:0]             link_speed,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`SCL_ADDR_W-1:0] paddr,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   mdio_oe,
  input wire logic                   link10_indicator,
  input wire logic                   link100_indicator,
  input wire logic                   link1000_indicator,
  input wire logic                   activity_indicator,
  input wire logic                   powerdown_active,
  input wire logic                   pll_enable
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // One cycle of slack: pll may follow the power-down flag a cycle late
  a_pll_policy: assert property (!pll_enable |-> powerdown_active || $past(powerdown_active))
    else $error("pll stopped outside power-down");
  a_pd_track: assert property ($rose(hw_powerdown_in) ##1 hw_powerdown_in [*2] |=> powerdown_active)
    else $error("power-down not entered");
  a_link_onehot: assert property ($onehot0({link10_indicator, link100_indicator, link1000_indicator}))
    else $error("several link indicators lit");
  a_link10_src: assert property (link10_indicator |-> $past(link_up) && $past(link_speed) == 2'b00)
    else $error("10M indicator without 10M link");
  a_act_link: assert property (activity_indicator |-> $past(link_up))
    else $error("activity shown without link");
  a_oe_by_write: assert property ($rose(mdio_oe) |-> $past(psel && penable && pwrite && pready && paddr == `SCL_ADDR_MGMT))
    else $error("data line enabled without write");
  a_hwrst_idle: assert property (!sys_reset_n [*6] |-> !link100_indicator && !link1000_indicator)
    else $error("strap drive during hardware reset");
  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready in first access cycle");
  a_unmapped_err: assert property (pready && paddr > `SCL_ADDR_MGMT |-> pslverr)
    else $error("unmapped access without error");
endmodule
bind scl_top scl_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .sys_reset_n(sys_reset_n),
  .hw_powerdown_in(hw_powerdown_in), .link_up(link_up), .link_speed(link_speed), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .mdio_oe(mdio_oe), .link10_indicator(link10_indicator), .link100_indicator(link100_indicator),
  .link1000_indicator(link1000_indicator), .activity_indicator(activity_indicator),
  .powerdown_active(powerdown_active), .pll_enable(pll_enable));

// file: tb/strap_config_latch_bench.sv
// Self-checking bench for the strap latch
`timescale 1ns/1ps
`include "scl_params.svh"
module strap_config_latch_bench;
  logic        sys_clk, sys_rst, sys_reset_n, hw_powerdown_in, link_up, activity_event, mdc;
  logic        psel, penable, pwrite, pready, pslverr, err, pol_up, mdio_in, mdio_out, mdio_oe;
  logic        link10_indicator, link100_indicator, link1000_indicator, activity_indicator;
  logic        powerdown_active, pll_enable, pause_adv, powerdown_pll_policy_strap;
  logic [1:0]  link_speed;
  logic [2:0]  phy_station_addr;
  logic [3:0]  ext_mode_field, straps;
  logic [7:0]  sel;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, tests_run;
  // Rows: strap choices {s3,s2,s1,s0}, then expected {mode, pause, addr}
  logic [15:0] rows [4] = '{16'h9c1c, 16'he9a5, 16'hb63a, 16'hc383};

  scl_board u_board (.sel(sel), .pol_up(pol_up), .l100(link100_indicator),
    .l1000(link1000_indicator), .oe(mdio_oe), .dout(mdio_out), .strap(straps),
    .pol(powerdown_pll_policy_strap), .din(mdio_in));
  scl_top dut (.sys_clk, .sys_rst, .sys_reset_n, .cfg_strap_zero(straps[0]),
    .cfg_strap_one(straps[1]), .cfg_strap_two(straps[2]), .cfg_strap_three(straps[3]),
    .powerdown_pll_policy_strap, .hw_powerdown_in, .link_up, .link_speed, .activity_event,
    .mdc, .mdio_in, .mdio_out, .mdio_oe, .link10_indicator, .link100_indicator,
    .link1000_indicator, .activity_indicator, .powerdown_active, .pll_enable,
    .phy_station_addr, .pause_adv, .ext_mode_field, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr);

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang();
    num_errors++;
    report_and_stop();
  endtask

  // Read data and error are taken at the edge that sees pready high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[`SCL_F_DONE] !== 1'b1)
    begin
      apb(1'b0, `SCL_ADDR_STATUS, 32'h0);
      n++;
      if (n > 100)
        hang();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {sys_rst, sys_reset_n, hw_powerdown_in, link_up, activity_event, mdc} = 6'b110000;
    {psel, penable, pwrite, pol_up, link_speed, paddr, pwdata, sel} = '0;
    num_errors = 0;
    tests_run = 0;
    tick(3);
    chk(32'({pll_enable, ext_mode_field, pause_adv, phy_station_addr}), 32'h100);
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `SCL_ADDR_MODES, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      sel <= rows[i][15:8];
      pol_up <= i[0];
      sys_reset_n <= 1'b0;
      tick(8);
      @(posedge sys_clk);
      sys_reset_n <= 1'b1;
      wait_done();
      chk(32'(rd[8:0]), 32'({i[0], rows[i][7:0]}));
      chk(32'({ext_mode_field, pause_adv, phy_station_addr}), 32'(rows[i][7:0]));
      apb(1'b0, `SCL_ADDR_MODES, 32'h0);
      chk(rd, 32'(rows[i][7:0]));
      hw_powerdown_in <= 1'b1;
      tick(6);
      chk(32'({powerdown_active, pll_enable}), 32'({1'b1, i[0]}));
      @(posedge sys_clk);
      hw_powerdown_in <= 1'b0;
    end
    // Straps moved after the pass must not reach the latched fields
    sel <= 8'h00;
    pol_up <= 1'b0;
    tick(200);
    apb(1'b0, `SCL_ADDR_STATUS, 32'h0);
    chk(rd, 32'hb83);
    apb(1'b1, `SCL_ADDR_MODES, 32'hffff_ff5a);
    apb(1'b0, `SCL_ADDR_MODES, 32'h0);
    chk(rd, 32'h5a);
    chk(32'({ext_mode_field, pause_adv, phy_station_addr}), 32'h5a);
    apb(1'b0, 12'h010, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    mdc <= 1'b1;
    apb(1'b1, `SCL_ADDR_MGMT, 32'h8);
    tick(3);
    chk(32'({mdio_oe, mdio_out}), 32'h2);
    apb(1'b0, `SCL_ADDR_MGMT, 32'h0);
    chk(rd, 32'h9);
    apb(1'b1, `SCL_ADDR_MGMT, 32'h0);
    tick(3);
    apb(1'b0, `SCL_ADDR_MGMT, 32'h0);
    chk(rd, 32'h3);
    link_up <= 1'b1;
    for (int s = 0; s < 3; s++)
    begin
      @(posedge sys_clk);
      link_speed <= 2'(s);
      tick(3);
      chk(32'({link1000_indicator, link100_indicator, link10_indicator}), 32'(1 << s));
    end
    // Indicator enable off must darken a live link
    apb(1'b1, `SCL_ADDR_CTRL, 32'h0);
    tick(2);
    chk(32'(link1000_indicator), 32'h0);
    apb(1'b0, `SCL_ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `SCL_ADDR_CTRL, 32'h1);
    tick(2);
    chk(32'(link1000_indicator), 32'h1);
    @(posedge sys_clk);
    activity_event <= 1'b1;
    @(posedge sys_clk);
    activity_event <= 1'b0;
    tick(3);
    chk(32'(activity_indicator), 32'h1);
    @(posedge sys_clk);
    link_up <= 1'b0;
    tick(3);
    chk(32'({activity_indicator, link1000_indicator}), 32'h0);
    report_and_stop();
  end
endmodule
